// ===== lintc_pkg.sv
// constants, types and register layout of the transceiver mode control
// assumes a 10 MHz system clock and an AHB-Lite register bus
package lintc_pkg;
    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int TIMEOUT_US = 10000;
    localparam int TO_CNT_W = 24;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] OFS_TRANSCEIVER_CONTROL_STATUS = 8'h00;
    localparam logic [7:0] OFS_IRQ_CTRL = 8'h04;
    localparam logic [7:0] OFS_FLAG_CLR = 8'h08;

    // ************************************************************
    // field positions of the control and status word and the interrupt control word
    // ************************************************************
    localparam int POS_ERR_CLR = 24;
    localparam int POS_HV_EN = 21;
    localparam int POS_RES_ONES = 19;
    localparam int POS_TRANSMITTER_STATE_FEEDBACK = 16;
    localparam int POS_SLOPE_FB = 13;
    localparam int POS_SLOPE_SEL = 11;
    localparam int POS_RXD = 10;
    localparam int POS_TXD = 9;
    localparam int POS_TO_FLAG = 6;
    localparam int POS_OC_FLAG = 5;
    localparam int POS_OT_FLAG = 4;
    localparam int POS_CFG_ERR = 3;
    localparam int POS_MODE = 1;
    localparam int POS_OVERCURRENT_IRQ_ENABLE = 0;
    localparam int POS_OT_IE = 1;
    localparam logic [1:0] RES_ONES = 2'h3;

    // ************************************************************
    // codes
    // ************************************************************
    localparam logic [1:0] MODE_SLEEP = 2'h0;
    localparam logic [1:0] MODE_LISTEN = 2'h1;
    localparam logic [1:0] MODE_NORMAL = 2'h3;
    localparam logic [2:0] MFB_SLEEP = 3'h1;
    localparam logic [2:0] MFB_LISTEN = 3'h5;
    localparam logic [2:0] MFB_NORMAL = 3'h7;
    localparam logic [2:0] SFB_LAST_OK = 3'h4;
    localparam logic [1:0] SLOPE_RESET = 2'h0;
    localparam logic [1:0] TRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {
        LINTC_SLOPE_NORMAL = 2'b00,
        LINTC_SLOPE_FAST = 2'b01,
        LINTC_SLOPE_LOW = 2'b10,
        LINTC_SLOPE_FLASH = 2'b11
    } lintc_slope_t;

    typedef enum logic [1:0] {
        LINTC_SLEEP = 2'b00,
        LINTC_LISTEN = 2'b01,
        LINTC_NORMAL = 2'b10,
        LINTC_HVPIN = 2'b11
    } lintc_mode_t;

    // analog feedback and supervision inputs
    typedef struct packed {
        logic [2:0] modeFb;
        logic [2:0] slopeFb;
        logic supplyUv;
        logic overTemp;
        logic overCurrent;
        logic rxd;
    } lintc_ana_t;

    // transceiver control outputs
    typedef struct packed {
        logic txEnable;
        logic rxEnable;
        logic wakeEnable;
        lintc_slope_t slope;
    } lintc_ctl_t;
endpackage

// ===== lintc_top.sv
// transceiver mode state machine, error flags and AHB-Lite register slave
// assumes analog inputs and uart transmit already synchronous to mclk
//
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps

// Functional notes
// - sleep disables transmit and receive; only the wake receiver stays on
// - hv pin state drives bus from the drive bit, line level readable
// - sleep to listen-only: listen requested, feedback ok, hv enable clear
// - listen-only goes to sleep when sleep is requested
// - sleep to normal: normal requested, feedback ok, no hv, no fault flags
// - normal goes to sleep when sleep is requested
// - normal drops to listen-only on request, bad feedback or any fault
// - listen-only to normal: normal requested, feedback ok, no faults
// - hv pin entry needs hv bit first, then normal request, no overtemperature or overcurrent flag
// - hv pin to sleep on sleep request with hv bit, bad feedback, overtemperature or overcurrent flag
// - mode feedback 001 sleep, 101 listen, 111 normal, else mode error
// - long dominant transmit forces listen-only, recessive bus, timeout flag
// - transmitter returns only after dominant ends and flag is cleared
// - no timeout supervision in the hv pin state
// - overcurrent sets its flag and normal drops to listen-only until the flag is cleared
// - overcurrent flag clearable but set again while condition lasts
// - overcurrent interrupt on shared line ten when enabled
// - overtemperature sets its flag; normal drops to listen-only, hv pin to sleep; leaves after clear
// - overtemperature interrupt on shared line ten when enabled
// - slope writes ignored in normal state
// - slope feedback 000 off, 001-100 valid slopes, 101-111 slope error
// - slope select decodes 00 normal, 01 fast, 10 low, 11 flash
// - hv drive bit 0 pulls line low, 1 releases it to pull-up
// - writing one to error clear bit clears config error flag
module lintc_top #(
    parameter int TIMEOUT_CYCLES = lintc_pkg::TIMEOUT_US * 1000 / lintc_pkg::CLK_PERIOD_NS
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // analog side
    input wire lintc_pkg::lintc_ana_t ana,
    output lintc_pkg::lintc_ctl_t ctl,
    // uart transmit, low is dominant
    input wire logic uartTxd,
    // bus pin driver, enable low while pulling low
    output logic busOut,
    output logic busOeN,
    // shared interrupt line ten
    output logic irqLine10
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        lintc_pkg::lintc_mode_t mode;
        logic [1:0] reqMode;
        logic hvEnable;
        logic normalAfterHv;
        lintc_pkg::lintc_slope_t slope;
        logic txdBit;
        logic toFlag;
        logic ocFlag;
        logic otFlag;
        logic cfgErr;
        logic ocIe;
        logic otIe;
        logic [lintc_pkg::TO_CNT_W-1:0] toCount;
        logic wrPend;
        logic rdPend;
        logic [7:0] addr;
        logic [31:0] rdata;
    } lintc_state_t;

    localparam logic [lintc_pkg::TO_CNT_W-1:0] TO_LIMIT = TIMEOUT_CYCLES[lintc_pkg::TO_CNT_W-1:0];
    // local names of the package's mode codes
    localparam lintc_pkg::lintc_mode_t LINTC_SLEEP = lintc_pkg::LINTC_SLEEP;
    localparam lintc_pkg::lintc_mode_t LINTC_LISTEN = lintc_pkg::LINTC_LISTEN;
    localparam lintc_pkg::lintc_mode_t LINTC_NORMAL = lintc_pkg::LINTC_NORMAL;
    localparam lintc_pkg::lintc_mode_t LINTC_HVPIN = lintc_pkg::LINTC_HVPIN;

    lintc_state_t cur;
    lintc_state_t next_cur;
    logic fbOk;
    logic modeFbOk;
    logic slopeFbOk;
    logic faultFree;
    logic toHit;
    logic addrPhase;
    logic wrCtrl;
    logic wrIrq;
    logic wrClr;
    logic [31:0] ctrlWord;
    logic [31:0] rdWord;

    // ************************************************************
    // feedback decode
    // ************************************************************
    always_comb begin
        modeFbOk = (ana.modeFb == lintc_pkg::MFB_SLEEP) || (ana.modeFb == lintc_pkg::MFB_LISTEN)
            || (ana.modeFb == lintc_pkg::MFB_NORMAL);
        slopeFbOk = (ana.slopeFb <= lintc_pkg::SFB_LAST_OK);
        fbOk = modeFbOk && slopeFbOk;
        faultFree = !ana.supplyUv && !cur.otFlag && !cur.ocFlag && !cur.toFlag;
        toHit = (cur.toCount >= TO_LIMIT) && !uartTxd;
    end

    // ************************************************************
    // register view
    // ************************************************************
    always_comb begin
        ctrlWord = 32'h0000_0000;
        ctrlWord[lintc_pkg::POS_HV_EN] = cur.hvEnable;
        ctrlWord[lintc_pkg::POS_RES_ONES +: 2] = lintc_pkg::RES_ONES;
        ctrlWord[lintc_pkg::POS_TRANSMITTER_STATE_FEEDBACK +: 3] = ana.modeFb;
        ctrlWord[lintc_pkg::POS_SLOPE_FB +: 3] = ana.slopeFb;
        ctrlWord[lintc_pkg::POS_SLOPE_SEL +: 2] = cur.slope;
        ctrlWord[lintc_pkg::POS_RXD] = ana.rxd;
        ctrlWord[lintc_pkg::POS_TXD] = cur.txdBit;
        ctrlWord[lintc_pkg::POS_TO_FLAG] = cur.toFlag;
        ctrlWord[lintc_pkg::POS_OC_FLAG] = cur.ocFlag;
        ctrlWord[lintc_pkg::POS_OT_FLAG] = cur.otFlag;
        ctrlWord[lintc_pkg::POS_CFG_ERR] = cur.cfgErr;
        ctrlWord[lintc_pkg::POS_MODE +: 2] = cur.reqMode;
        rdWord = 32'h0000_0000;
        case (cur.addr)
            lintc_pkg::OFS_TRANSCEIVER_CONTROL_STATUS: begin
                rdWord = ctrlWord;
            end
            lintc_pkg::OFS_IRQ_CTRL: begin
                rdWord[lintc_pkg::POS_OVERCURRENT_IRQ_ENABLE] = cur.ocIe;
                rdWord[lintc_pkg::POS_OT_IE] = cur.otIe;
            end
            default: begin
                rdWord = 32'h0000_0000;
            end
        endcase
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_cur = cur;
        addrPhase = hsel && hready && (htrans == lintc_pkg::TRANS_NONSEQ);
        wrCtrl = cur.wrPend && (cur.addr == lintc_pkg::OFS_TRANSCEIVER_CONTROL_STATUS);
        wrIrq = cur.wrPend && (cur.addr == lintc_pkg::OFS_IRQ_CTRL);
        wrClr = cur.wrPend && (cur.addr == lintc_pkg::OFS_FLAG_CLR);
        // bus phases: writes zero wait, reads one wait state
        next_cur.wrPend = addrPhase && hwrite;
        next_cur.rdPend = addrPhase && !hwrite;
        if (addrPhase) begin
            next_cur.addr = haddr[7:0];
        end
        if (cur.rdPend) begin
            next_cur.rdata = rdWord;
        end
        // software writes
        if (wrCtrl) begin
            next_cur.hvEnable = hwdata[lintc_pkg::POS_HV_EN];
            next_cur.reqMode = hwdata[lintc_pkg::POS_MODE +: 2];
            next_cur.txdBit = hwdata[lintc_pkg::POS_TXD];
            if (cur.mode != LINTC_NORMAL) begin
                next_cur.slope = lintc_pkg::lintc_slope_t'(hwdata[lintc_pkg::POS_SLOPE_SEL +: 2]);
            end
            next_cur.normalAfterHv = cur.hvEnable && hwdata[lintc_pkg::POS_HV_EN]
                && (hwdata[lintc_pkg::POS_MODE +: 2] == lintc_pkg::MODE_NORMAL);
            if (hwdata[lintc_pkg::POS_ERR_CLR]) begin
                next_cur.cfgErr = 1'b0;
            end
        end
        if (wrIrq) begin
            next_cur.ocIe = hwdata[lintc_pkg::POS_OVERCURRENT_IRQ_ENABLE];
            next_cur.otIe = hwdata[lintc_pkg::POS_OT_IE];
        end
        if (wrClr) begin
            if (hwdata[lintc_pkg::POS_TO_FLAG]) begin
                next_cur.toFlag = 1'b0;
            end
            if (hwdata[lintc_pkg::POS_OC_FLAG]) begin
                next_cur.ocFlag = 1'b0;
            end
            if (hwdata[lintc_pkg::POS_OT_FLAG]) begin
                next_cur.otFlag = 1'b0;
            end
        end
        // hardware sets come last so they win over clears
        if (!fbOk) begin
            next_cur.cfgErr = 1'b1;
        end
        if (ana.overCurrent) begin
            next_cur.ocFlag = 1'b1;
        end
        if (ana.overTemp) begin
            next_cur.otFlag = 1'b1;
        end
        if (toHit && (cur.mode != LINTC_HVPIN)) begin
            next_cur.toFlag = 1'b1;
        end
        // dominant-time supervision
        if ((cur.mode == LINTC_HVPIN) || uartTxd) begin
            next_cur.toCount = '0;
        end else if (cur.toCount < TO_LIMIT) begin
            next_cur.toCount = cur.toCount + 1'b1;
        end
        // mode state machine
        case (cur.mode)
            LINTC_SLEEP: begin
                if (cur.hvEnable && cur.normalAfterHv && fbOk && !cur.otFlag && !cur.ocFlag) begin
                    next_cur.mode = LINTC_HVPIN;
                end else if ((cur.reqMode == lintc_pkg::MODE_LISTEN) && fbOk && !cur.hvEnable) begin
                    next_cur.mode = LINTC_LISTEN;
                end else if ((cur.reqMode == lintc_pkg::MODE_NORMAL) && fbOk && !cur.hvEnable
                    && faultFree) begin
                    next_cur.mode = LINTC_NORMAL;
                end
            end
            LINTC_LISTEN: begin
                if (cur.reqMode == lintc_pkg::MODE_SLEEP) begin
                    next_cur.mode = LINTC_SLEEP;
                end else if ((cur.reqMode == lintc_pkg::MODE_NORMAL) && fbOk && faultFree) begin
                    next_cur.mode = LINTC_NORMAL;
                end
            end
            LINTC_NORMAL: begin
                if (cur.reqMode == lintc_pkg::MODE_SLEEP) begin
                    next_cur.mode = LINTC_SLEEP;
                end else if ((cur.reqMode == lintc_pkg::MODE_LISTEN) || !fbOk || !faultFree
                    || toHit) begin
                    next_cur.mode = LINTC_LISTEN;
                end
            end
            LINTC_HVPIN: begin
                if (((cur.reqMode == lintc_pkg::MODE_SLEEP) && cur.hvEnable) || !fbOk
                    || cur.otFlag || cur.ocFlag) begin
                    next_cur.mode = LINTC_SLEEP;
                end
            end
            default: begin
                next_cur.mode = LINTC_SLEEP;
            end
        endcase
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cur <= '{mode: LINTC_SLEEP, reqMode: lintc_pkg::MODE_SLEEP,
                slope: lintc_pkg::lintc_slope_t'(lintc_pkg::SLOPE_RESET), txdBit: 1'b1,
                default: '0};
        end else begin
            cur <= next_cur;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    always_comb begin
        hreadyout = !cur.rdPend;
        hresp = 1'b0;
        hrdata = cur.rdata;
        ctl.txEnable = (cur.mode == LINTC_NORMAL) && !cur.toFlag && !cur.otFlag;
        ctl.rxEnable = (cur.mode != LINTC_SLEEP);
        ctl.wakeEnable = (cur.mode == LINTC_SLEEP);
        ctl.slope = cur.slope;
        busOut = 1'b0;
        if (cur.mode == LINTC_HVPIN) begin
            busOeN = cur.txdBit;
        end else begin
            busOeN = !(ctl.txEnable && !uartTxd && !toHit);
        end
        irqLine10 = (cur.ocFlag && cur.ocIe) || (cur.otFlag && cur.otIe);
    end

    // ************************************************************
    // assertions
    // ************************************************************
    sleep_paths_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (cur.mode == LINTC_SLEEP) |-> (!ctl.txEnable && !ctl.rxEnable && ctl.wakeEnable))
        else $error("sleep state leaves a path enabled");
    hv_drive_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (cur.mode == LINTC_HVPIN) |-> (busOeN == cur.txdBit))
        else $error("hv pin drive does not follow drive bit");
    listen_to_sleep_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (cur.mode == LINTC_LISTEN && cur.reqMode == lintc_pkg::MODE_SLEEP)
        |=> (cur.mode == LINTC_SLEEP))
        else $error("listen-only ignored sleep request");
    normal_needs_ok_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ($past(cur.mode) == LINTC_SLEEP && cur.mode == LINTC_NORMAL)
        |-> ($past(fbOk) && !$past(cur.hvEnable) && $past(faultFree)))
        else $error("normal entered from sleep without conditions");
    normal_fault_drop_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (cur.mode == LINTC_NORMAL && cur.reqMode != lintc_pkg::MODE_SLEEP && !faultFree)
        |=> (cur.mode == LINTC_LISTEN))
        else $error("normal kept despite fault");
    timeout_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (toHit && cur.mode == LINTC_NORMAL) |=> (cur.toFlag && cur.mode != LINTC_NORMAL))
        else $error("timeout did not set flag or leave normal");
    hv_no_timeout_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (cur.mode == LINTC_HVPIN) [*2] |-> (cur.toCount == '0))
        else $error("timeout counting in hv pin state");
    set_beats_clr_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (wrClr && hwdata[lintc_pkg::POS_OC_FLAG] && ana.overCurrent) |=> cur.ocFlag)
        else $error("overcurrent flag lost to clear");
    slope_locked_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (cur.mode == LINTC_NORMAL && $past(cur.mode) == LINTC_NORMAL) |-> $stable(cur.slope))
        else $error("slope changed in normal state");
    irq_line_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (cur.ocIe && ana.overCurrent) |=> irqLine10)
        else $error("overcurrent interrupt missing");
    err_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (wrCtrl && hwdata[lintc_pkg::POS_ERR_CLR] && fbOk) |=> !cur.cfgErr)
        else $error("config error not cleared");
endmodule

// ===== lintc_afe_model.sv
// analog front end model: mode and slope feedback, fault levels, bus line
// assumes the block's control outputs and pin enable settle within a cycle
`timescale 1ns/1ps
module lintc_afe_model (
    // from the block
    input wire lintc_pkg::lintc_ctl_t ctl,
    input wire logic busOeN,
    // injected faults, bit 3 enables a code override
    input wire logic [3:0] modeOvr,
    input wire logic [3:0] slopeOvr,
    input wire logic [2:0] fault,
    // to the block
    output lintc_pkg::lintc_ana_t ana
);
    always_comb begin
        ana.modeFb = ctl.wakeEnable ? 3'h1 : (ctl.txEnable ? 3'h7 : 3'h5);
        if (modeOvr[3]) begin
            ana.modeFb = modeOvr[2:0];
        end
        case (ctl.slope)
            lintc_pkg::LINTC_SLOPE_NORMAL: ana.slopeFb = 3'h2;
            lintc_pkg::LINTC_SLOPE_FAST: ana.slopeFb = 3'h3;
            lintc_pkg::LINTC_SLOPE_LOW: ana.slopeFb = 3'h1;
            default: ana.slopeFb = 3'h4;
        endcase
        if (slopeOvr[3]) begin
            ana.slopeFb = slopeOvr[2:0];
        end
        ana.supplyUv = fault[2];
        ana.overTemp = fault[1];
        ana.overCurrent = fault[0];
        // released line floats up through the pull-up
        ana.rxd = busOeN;
    end
endmodule

// ===== lin_transceiver_mode_control_tb.sv
// self-checking bench of the transceiver mode control
// assumes lintc_top with a shortened transmit timeout and the analog model
`timescale 1ns/1ps
module lin_transceiver_mode_control_tb;
    localparam int TO = 20;
    localparam logic [7:0] A_CS = lintc_pkg::OFS_TRANSCEIVER_CONTROL_STATUS;
    localparam logic [7:0] A_IE = lintc_pkg::OFS_IRQ_CTRL;
    localparam logic [7:0] A_FC = lintc_pkg::OFS_FLAG_CLR;
    localparam logic [1:0] M_S = lintc_pkg::MODE_SLEEP;
    localparam logic [1:0] M_L = lintc_pkg::MODE_LISTEN;
    localparam logic [1:0] M_N = lintc_pkg::MODE_NORMAL;
    localparam logic [2:0] S_SLP = 3'b001;
    localparam logic [2:0] S_LSN = 3'b010;
    localparam logic [2:0] S_NRM = 3'b110;
    logic mclk, rst_n, hsel, hwrite, hreadyout, hresp, uartTxd, busOut, busOeN, irqLine10;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [3:0] modeOvr, slopeOvr;
    logic [2:0] fault;
    logic rdPend;
    lintc_pkg::lintc_ana_t ana;
    lintc_pkg::lintc_ctl_t ctl;
    logic [63:0] expQ[$];
    int n_errors, n_checks;

    lintc_top #(.TIMEOUT_CYCLES(TO)) u_dut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .ana(ana), .ctl(ctl), .uartTxd(uartTxd), .busOut(busOut), .busOeN(busOeN),
        .irqLine10(irqLine10));
    lintc_afe_model u_afe (.ctl(ctl), .busOeN(busOeN), .modeOvr(modeOvr),
        .slopeOvr(slopeOvr), .fault(fault), .ana(ana));

    // ************************************************************
    // shared tasks
    // ************************************************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task conclude;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= lintc_pkg::TRANS_NONSEQ;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        expQ.push_back({m, e});
        ahb(1'b0, a, 32'h0);
    endtask

    task wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task pins(input logic [2:0] e);
        chk({29'h0, ctl.txEnable, ctl.rxEnable, ctl.wakeEnable}, {29'h0, e});
    endtask

    function automatic logic [31:0] cw(input logic hv, input logic [1:0] sl,
                                       input logic txd, input logic [1:0] md);
        cw = 32'h0;
        cw[lintc_pkg::POS_HV_EN] = hv;
        cw[lintc_pkg::POS_SLOPE_SEL +: 2] = sl;
        cw[lintc_pkg::POS_TXD] = txd;
        cw[lintc_pkg::POS_MODE +: 2] = md;
    endfunction

    // ************************************************************
    // read data monitor
    // ************************************************************
    always @(posedge mclk) begin
        if (rdPend && hreadyout === 1'b1) begin
            rdPend <= 1'b0;
            chk(hrdata & expQ[0][63:32], expQ[0][31:0]);
            void'(expQ.pop_front());
        end
        if (hsel && hreadyout && htrans == lintc_pkg::TRANS_NONSEQ && !hwrite) begin
            rdPend <= 1'b1;
        end
    end

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        conclude();
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        int i;
        logic e;
        logic [2:0] code [4];
        code = '{3'h2, 3'h3, 3'h1, 3'h4};
        {rst_n, hsel, hwrite, uartTxd, rdPend} = 5'b00010;
        {haddr, hwdata, htrans} = '0;
        {modeOvr, slopeOvr, fault} = '0;
        n_errors = 0;
        n_checks = 0;
        void'($urandom(32'hc1a8));
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        wt(1);
        pins(S_SLP);
        chk({30'h0, hresp, busOut}, 32'h0);
        rd(A_CS, 32'h0019_4600, 32'hFFFF_FFFF);
        rd(A_IE, 32'h0, 32'hFFFF_FFFF);
        rd(8'h0C, 32'h0, 32'hFFFF_FFFF);
        for (i = 0; i < 4; i++) begin
            ahb(1'b1, A_CS, cw(1'b0, 2'(i), 1'b1, M_S));
            wt(1);
            chk({30'h0, ctl.slope}, i);
            rd(A_CS, {16'h0, code[i], 13'h0}, 32'h0000_E000);
        end
        ahb(1'b1, A_CS, cw(1'b0, 2'h3, 1'b1, M_N));
        wt(2);
        pins(S_NRM);
        ahb(1'b1, A_CS, cw(1'b0, 2'($urandom % 3), 1'b1, M_N));
        wt(1);
        chk({30'h0, ctl.slope}, 32'h3);
        ahb(1'b1, A_CS, cw(1'b0, 2'h0, 1'b1, M_S));
        wt(2);
        pins(S_SLP);
        ahb(1'b1, A_CS, cw(1'b0, 2'h0, 1'b1, M_L));
        wt(2);
        pins(S_LSN);
        rd(A_CS, 32'h0005_0000, 32'h0007_0000);
        ahb(1'b1, A_CS, cw(1'b0, 2'h0, 1'b1, M_N));
        wt(2);
        pins(S_NRM);
        ahb(1'b1, A_CS, cw(1'b0, 2'h0, 1'b1, M_L));
        wt(2);
        pins(S_LSN);
        ahb(1'b1, A_CS, cw(1'b0, 2'h0, 1'b1, M_S));
        wt(2);
        pins(S_SLP);
        fault <= 3'b100;
        ahb(1'b1, A_CS, cw(1'b0, 2'h0, 1'b1, M_N));
        wt(3);
        pins(S_SLP);
        fault <= 3'b000;
        wt(3);
        pins(S_NRM);
        fault <= 3'b100;
        wt(3);
        pins(S_LSN);
        fault <= 3'b000;
        wt(3);
        pins(S_NRM);
        // high-voltage pin use: enable bit first, then normal request
        ahb(1'b1, A_CS, cw(1'b0, 2'h0, 1'b1, M_S));
        ahb(1'b1, A_CS, cw(1'b1, 2'h0, 1'b1, M_S));
        ahb(1'b1, A_CS, cw(1'b1, 2'h0, 1'b1, M_L));
        wt(2);
        pins(S_SLP);
        ahb(1'b1, A_CS, cw(1'b1, 2'h0, 1'b1, M_N));
        wt(3);
        pins(S_LSN);
        ahb(1'b1, A_CS, cw(1'b1, 2'h0, 1'b0, M_N));
        wt(1);
        chk({31'h0, busOeN}, 32'h0);
        rd(A_CS, 32'h0, 32'h0000_0400);
        ahb(1'b1, A_CS, cw(1'b1, 2'h0, 1'b1, M_N));
        uartTxd <= 1'b0;
        wt(TO + 10);
        chk({31'h0, busOeN}, 32'h1);
        rd(A_CS, 32'h0, 32'h0000_0040);
        uartTxd <= 1'b1;
        ahb(1'b1, A_CS, cw(1'b1, 2'h0, 1'b1, M_S));
        wt(2);
        pins(S_SLP);
        ahb(1'b1, A_CS, cw(1'b1, 2'h0, 1'b1, M_N));
        wt(3);
        fault <= 3'b010;
        wt(3);
        pins(S_SLP);
        fault <= 3'b000;
        ahb(1'b1, A_CS, cw(1'b0, 2'h0, 1'b1, M_S));
        ahb(1'b1, A_FC, 32'h0000_0010);
        // overtemperature with its interrupt enabled
        ahb(1'b1, A_IE, 32'h0000_0002);
        ahb(1'b1, A_CS, cw(1'b0, 2'h0, 1'b1, M_N));
        wt(3);
        fault <= 3'b010;
        uartTxd <= 1'b0;
        wt(3);
        pins(S_LSN);
        chk({30'h0, irqLine10, busOeN}, 32'h3);
        uartTxd <= 1'b1;
        ahb(1'b1, A_FC, 32'h0000_0010);
        rd(A_CS, 32'h0000_0010, 32'h0000_0010);
        fault <= 3'b000;
        wt(3);
        pins(S_LSN);
        ahb(1'b1, A_FC, 32'h0000_0010);
        wt(3);
        pins(S_NRM);
        chk({31'h0, irqLine10}, 32'h0);
        // overcurrent, interrupt masked then enabled
        ahb(1'b1, A_IE, 32'h0000_0000);
        fault <= 3'b001;
        wt(3);
        chk({31'h0, irqLine10}, 32'h0);
        rd(A_CS, 32'h0000_0020, 32'h0000_0020);
        ahb(1'b1, A_IE, 32'h0000_0001);
        wt(1);
        chk({31'h0, irqLine10}, 32'h1);
        ahb(1'b1, A_FC, 32'h0000_0020);
        rd(A_CS, 32'h0000_0020, 32'h0000_0020);
        fault <= 3'b000;
        ahb(1'b1, A_FC, 32'h0000_0020);
        wt(3);
        chk({31'h0, irqLine10}, 32'h0);
        pins(S_NRM);
        // transmit held dominant past the limit
        uartTxd <= 1'b0;
        wt(2);
        chk({31'h0, busOeN}, 32'h0);
        wt(TO + 5);
        chk({31'h0, busOeN}, 32'h1);
        pins(S_LSN);
        rd(A_CS, 32'h0000_0040, 32'h0000_0040);
        uartTxd <= 1'b1;
        wt(3);
        pins(S_LSN);
        ahb(1'b1, A_FC, 32'h0000_0040);
        wt(3);
        pins(S_NRM);
        slopeOvr <= 4'hF;
        wt(3);
        pins(S_LSN);
        slopeOvr <= 4'h0;
        ahb(1'b1, A_CS, cw(1'b0, 2'h0, 1'b1, M_S) | 32'h0100_0000);
        // every feedback code, then the error clear
        for (i = 0; i < 16; i++) begin
            if (i < 8) begin
                modeOvr <= {1'b1, 3'(i)};
            end else begin
                slopeOvr <= {1'b1, 3'(i)};
            end
            e = (i < 8) ? !(i == 1 || i == 5 || i == 7) : (i % 8 > 4);
            wt(2);
            rd(A_CS, {28'h0, e, 3'h0}, 32'h0000_0008);
            modeOvr <= 4'h0;
            slopeOvr <= 4'h0;
            ahb(1'b1, A_CS, cw(1'b0, 2'h0, 1'b1, M_S) | 32'h0100_0000);
            wt(1);
            rd(A_CS, 32'h0, 32'h0000_0008);
        end
        wt(2);
        conclude();
    end
endmodule
